// ---- hw/ssr_top.sv ----
`timescale 1ns/1ps
// Status reporting hierarchy with its register port.
module ssr_top
  import ssr_pkg::*;
(
  // Clock, enable and reset.
  input  wire logic                       ref_clk,
  input  wire logic                       ce,
  input  wire logic                       rst,
  // Register port.
  input  wire logic [SSR_AW-1:0]          reg_addr,
  input  wire logic [SSR_DW-1:0]          reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic      [SSR_DW-1:0]          reg_rdata,
  // Hardware status pins, group g at bits g*15 upward.
  input  wire logic [SSR_NGRP*SSR_SW-1:0] hw_cond,
  // Same-clock sources from the message layer.
  input  wire logic [SSR_EW-1:0]          esr_set,
  input  wire logic                       err_queue_busy,
  input  wire logic                       msg_avail,
  // Summary outputs.
  output logic      [SSR_EW-1:0]          status_byte,
  output logic                            srq,
  output logic                            ist
);
  logic [SSR_NGRP*SSR_SW-1:0]       cond_s1_q;
  logic [SSR_NGRP*SSR_SW-1:0]       cond_s2_q;
  logic [SSR_NGRP-1:0][SSR_SW-1:0]  child_cond;
  logic [SSR_NGRP-1:0][SSR_SW-1:0]  grp_rdval;
  logic [SSR_NGRP-1:0]              grp_sum;
  logic [SSR_EW-1:0]                sre_q;
  logic [SSR_EW-1:0]                ese_q;
  logic [SSR_EW-1:0]                esr_q;
  logic [SSR_EW-1:0]                ppe_q;
  logic [SSR_EW-1:0]                stb_q;
  logic                             srq_q;
  logic                             ist_q;
  logic [SSR_DW-1:0]                rdata_q;
  logic [SSR_EW-1:0]                stb_w;
  logic [SSR_EW-1:0]                stb_full;
  logic [SSR_EW-1:0]                esr_d;
  logic [SSR_DW-1:0]                com_rd;
  logic [SSR_DW-1:0]                rd_mux;

  // Address fields and decodes.
  wire [SSR_GW-1:0]   grp_sel  = reg_addr[SSR_AW-1:SSR_SUBW];
  wire [SSR_SUBW-1:0] sub_sel  = reg_addr[SSR_SUBW-1:0];
  wire                grp_hit  = grp_sel < SSR_GW'(SSR_NGRP);
  wire                com_hit  = grp_sel == G_COM;
  wire                com_wr   = reg_wr && com_hit;
  wire                esr_clr  = reg_rd && com_hit && (sub_sel == COM_ESR);
  wire                mss_w    = |(stb_w & sre_q & ~(SSR_EW'(1) << STB_MSS));

  // Pins pass two flip-flops before the groups see them.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cond_s1_q <= '0;
      cond_s2_q <= '0;
    end else if (ce) begin
      cond_s1_q <= hw_cond;
      cond_s2_q <= cond_s1_q;
    end
  end

  // Child summaries land on the parents' condition bits.
  always_comb begin
    child_cond = '0;
    child_cond[G_OPER][OPER_CAL_BIT]  = grp_sum[G_OPCAL];
    child_cond[G_OPER][OPER_MEAS_BIT] = grp_sum[G_OPMEAS];
    child_cond[G_OPER][OPER_TRIG_BIT] = grp_sum[G_OPTRIG];
    child_cond[G_OPER][OPER_SENS_BIT] = grp_sum[G_OPSENS];
    child_cond[G_OPER][OPER_LLF_BIT]  = grp_sum[G_LLF];
    child_cond[G_OPER][OPER_ULF_BIT]  = grp_sum[G_ULF];
    child_cond[G_QUES][QUES_POW_BIT]  = grp_sum[G_QPOW];
    child_cond[G_QUES][QUES_CAL_BIT]  = grp_sum[G_QCAL];
    child_cond[G_QUES][QUES_WIN_BIT]  = grp_sum[G_QWIN];
  end

  // The twelve status groups.
  ssr_grp_if gif [SSR_NGRP] ();
  for (genvar g = 0; g < SSR_NGRP; g++) begin : g_grp
    assign gif[g].cond  = cond_s2_q[g*SSR_SW +: SSR_SW] | child_cond[g];
    assign gif[g].wr    = reg_wr && (grp_sel == SSR_GW'(g));
    assign gif[g].rd    = reg_rd && (grp_sel == SSR_GW'(g));
    assign gif[g].sel   = sub_sel;
    assign gif[g].wdata = reg_wdata[SSR_SW-1:0];
    assign grp_rdval[g] = gif[g].rdval;
    assign grp_sum[g]   = gif[g].sum;
    ssr_group #(
      .W (SSR_SW)
    ) u_grp (
      .ref_clk (ref_clk),
      .ce      (ce),
      .rst     (rst),
      .bus     (gif[g].grp)
    );
  end

  // Status byte assembly.
  always_comb begin
    stb_w           = '0;
    stb_w[STB_DEV]  = grp_sum[G_DEV];
    stb_w[STB_ERR]  = err_queue_busy;
    stb_w[STB_QUES] = grp_sum[G_QUES];
    stb_w[STB_MAV]  = msg_avail;
    stb_w[STB_ESB]  = |(esr_q & ese_q);
    stb_w[STB_OPER] = grp_sum[G_OPER];
    stb_full          = stb_w;
    stb_full[STB_MSS] = mss_w;
  end

  // Standard event bits; a new event beats the read clear.
  assign esr_d = (esr_q & ~{SSR_EW{esr_clr}}) | esr_set;

  // Common register readback.
  assign com_rd = (sub_sel == COM_STB) ? SSR_DW'(stb_full) :
                  (sub_sel == COM_SRE) ? SSR_DW'(sre_q) :
                  (sub_sel == COM_ESR) ? SSR_DW'(esr_q) :
                  (sub_sel == COM_ESE) ? SSR_DW'(ese_q) :
                  (sub_sel == COM_PPE) ? SSR_DW'(ppe_q) : '0;

  // Group reads keep bit 15 at zero; unmapped reads give zero.
  assign rd_mux = grp_hit ? {1'b0, grp_rdval[grp_sel]} :
                  com_hit ? com_rd : '0;

  // Enable and event registers of the common set.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sre_q <= '0;
      ese_q <= '0;
      ppe_q <= '0;
      esr_q <= '0;
    end else if (ce) begin
      esr_q <= esr_d;
      if (com_wr && sub_sel == COM_SRE) sre_q <= reg_wdata[SSR_EW-1:0];
      if (com_wr && sub_sel == COM_ESE) ese_q <= reg_wdata[SSR_EW-1:0];
      if (com_wr && sub_sel == COM_PPE) ppe_q <= reg_wdata[SSR_EW-1:0];
    end
  end

  // Registered outputs and read data.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stb_q   <= '0;
      srq_q   <= 1'b0;
      ist_q   <= 1'b0;
      rdata_q <= '0;
    end else if (ce) begin
      stb_q   <= stb_full;
      srq_q   <= mss_w;
      ist_q   <= |(stb_full & ppe_q);
      rdata_q <= reg_rd ? rd_mux : '0;
    end
  end

  assign reg_rdata   = rdata_q;
  assign status_byte = stb_q;
  assign srq         = srq_q;
  assign ist         = ist_q;

  // Checks on the register port and the top level.
  msb_zero_a: assert property (@(posedge ref_clk) disable iff (rst)
    reg_rdata[SSR_DW-1] == 1'b0)
    else $error("Read data bit 15 is not zero.");
  read_idle_a: assert property (@(posedge ref_clk) disable iff (rst)
    ce && !reg_rd |=> (reg_rdata == '0))
    else $error("Read data present without a read.");
  ist_gate_a: assert property (@(posedge ref_clk) disable iff (rst)
    ce && ((stb_full & ppe_q) == '0) |=> !ist)
    else $error("Status flag set with nothing enabled.");
  esr_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
    ce && esr_clr && (esr_set == '0) |=> (esr_q == '0))
    else $error("Standard event read did not clear.");
  srq_gate_a: assert property (@(posedge ref_clk) disable iff (rst)
    ce && ((stb_w & sre_q) == '0) |=> !srq && !status_byte[STB_MSS])
    else $error("Service request without an enabled source.");
  meas_path_a: assert property (@(posedge ref_clk) disable iff (rst)
    gif[G_OPER].cond[OPER_MEAS_BIT] ==
      (grp_sum[G_OPMEAS] | cond_s2_q[G_OPER*SSR_SW+OPER_MEAS_BIT]))
    else $error("Measuring summary not on operation bit 4.");
endmodule

// ---- hw/ssr_pkg.sv ----
// Notes on behaviour
// - Each status group holds five subregisters.
// - Subregisters are 16 bits, 15 used.
// - Bit 15 always reads as zero.
// - Status reads stay within 0 to 32767.
// - Writes touch only mask and both filters.
// - Selector picks subregister; event is default.
// - Prefixed binary, hex, octal values also allowed.
// - One bit per source, same in all five.
// - Operation bit 4 means measurement running.
// - Status byte collects event, operation, questionable, device.
// - Individual status flag gated by poll enable.
// - Message available bit follows output queue.
// - Twelve named status groups are implemented.
// - Standard event register has its own access.
// - Rising condition sets event when rising filter set.
// - Falling condition sets event when falling filter set.
// - Event read clears; other reads do not.
// - Summary is OR of masked events, feeds parent.
package ssr_pkg;
  localparam int SSR_DW   = 16;
  localparam int SSR_SW   = 15;
  localparam int SSR_AW   = 7;
  localparam int SSR_SUBW = 3;
  localparam int SSR_GW   = 4;
  localparam int SSR_NGRP = 12;
  localparam int SSR_EW   = 8;

  // Group indices, taken from the upper address bits.
  localparam logic [SSR_GW-1:0] G_DEV    = 4'h0;
  localparam logic [SSR_GW-1:0] G_QUES   = 4'h1;
  localparam logic [SSR_GW-1:0] G_QPOW   = 4'h2;
  localparam logic [SSR_GW-1:0] G_QWIN   = 4'h3;
  localparam logic [SSR_GW-1:0] G_QCAL   = 4'h4;
  localparam logic [SSR_GW-1:0] G_OPER   = 4'h5;
  localparam logic [SSR_GW-1:0] G_OPCAL  = 4'h6;
  localparam logic [SSR_GW-1:0] G_OPMEAS = 4'h7;
  localparam logic [SSR_GW-1:0] G_OPTRIG = 4'h8;
  localparam logic [SSR_GW-1:0] G_OPSENS = 4'h9;
  localparam logic [SSR_GW-1:0] G_LLF    = 4'hA;
  localparam logic [SSR_GW-1:0] G_ULF    = 4'hB;
  localparam logic [SSR_GW-1:0] G_COM    = 4'hC;

  // Subregister selectors within a status group.
  localparam logic [SSR_SUBW-1:0] SUB_EVT  = 3'h0;
  localparam logic [SSR_SUBW-1:0] SUB_COND = 3'h1;
  localparam logic [SSR_SUBW-1:0] SUB_EN   = 3'h2;
  localparam logic [SSR_SUBW-1:0] SUB_RISE = 3'h3;
  localparam logic [SSR_SUBW-1:0] SUB_FALL = 3'h4;

  // Selectors of the common registers.
  localparam logic [SSR_SUBW-1:0] COM_STB = 3'h0;
  localparam logic [SSR_SUBW-1:0] COM_SRE = 3'h1;
  localparam logic [SSR_SUBW-1:0] COM_ESR = 3'h2;
  localparam logic [SSR_SUBW-1:0] COM_ESE = 3'h3;
  localparam logic [SSR_SUBW-1:0] COM_PPE = 3'h4;

  // Reset values of the writable subregisters.
  localparam logic [SSR_SW-1:0] RISE_RST = 15'h7FFF;
  localparam logic [SSR_SW-1:0] FALL_RST = 15'h0000;
  localparam logic [SSR_SW-1:0] EN_RST   = 15'h0000;

  // Summary bit positions in parent condition registers.
  localparam int OPER_CAL_BIT  = 0;
  localparam int OPER_MEAS_BIT = 4;
  localparam int OPER_TRIG_BIT = 5;
  localparam int OPER_SENS_BIT = 10;
  localparam int OPER_LLF_BIT  = 11;
  localparam int OPER_ULF_BIT  = 12;
  localparam int QUES_POW_BIT  = 3;
  localparam int QUES_CAL_BIT  = 8;
  localparam int QUES_WIN_BIT  = 9;

  // Status byte bit positions.
  localparam int STB_DEV  = 1;
  localparam int STB_ERR  = 2;
  localparam int STB_QUES = 3;
  localparam int STB_MAV  = 4;
  localparam int STB_ESB  = 5;
  localparam int STB_MSS  = 6;
  localparam int STB_OPER = 7;
endpackage

// ---- hw/ssr_grp_if.sv ----
`timescale 1ns/1ps
// Signals between the top and one status group.
interface ssr_grp_if;
  import ssr_pkg::*;
  logic [SSR_SW-1:0]   cond;
  logic                wr;
  logic                rd;
  logic [SSR_SUBW-1:0] sel;
  logic [SSR_SW-1:0]   wdata;
  logic [SSR_SW-1:0]   rdval;
  logic                sum;
  modport grp (input cond, wr, rd, sel, wdata, output rdval, sum);
  modport ctl (output cond, wr, rd, sel, wdata, input rdval, sum);
endinterface

// ---- hw/ssr_group.sv ----
`timescale 1ns/1ps
// One status group with its five subregisters.
module ssr_group
  import ssr_pkg::*;
#(
  parameter int W = SSR_SW
) (
  // Clock, enable and reset.
  input wire logic ref_clk,
  input wire logic ce,
  input wire logic rst,
  // Access from the top.
  ssr_grp_if.grp   bus
);
  logic [W-1:0] prev_q;
  logic [W-1:0] rise_q;
  logic [W-1:0] fall_q;
  logic [W-1:0] en_q;
  logic [W-1:0] ev_q;
  wire  [W-1:0] rise_ev;
  wire  [W-1:0] fall_ev;
  wire  [W-1:0] set_w;
  wire  [W-1:0] ev_d;
  wire          clr_w;

  // Edge filters; each bit works on its own.
  assign rise_ev = bus.cond & ~prev_q & rise_q;
  assign fall_ev = ~bus.cond & prev_q & fall_q;
  assign set_w   = rise_ev | fall_ev;
  assign clr_w   = bus.rd && (bus.sel == SUB_EVT);
  // A new event in the read cycle survives the clear.
  assign ev_d    = (ev_q & ~{W{clr_w}}) | set_w;
  assign bus.sum = |(ev_q & en_q);

  // Readback by selector; unknown selectors read zero.
  assign bus.rdval = (bus.sel == SUB_EVT)  ? ev_q :
                     (bus.sel == SUB_COND) ? bus.cond :
                     (bus.sel == SUB_EN)   ? en_q :
                     (bus.sel == SUB_RISE) ? rise_q :
                     (bus.sel == SUB_FALL) ? fall_q : '0;

  // Previous condition and latched events.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prev_q <= '0;
      ev_q   <= '0;
    end else if (ce) begin
      prev_q <= bus.cond;
      ev_q   <= ev_d;
    end
  end

  // Only the mask and the two filters accept writes.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rise_q <= W'(RISE_RST);
      fall_q <= W'(FALL_RST);
      en_q   <= W'(EN_RST);
    end else if (ce && bus.wr) begin
      if (bus.sel == SUB_EN) en_q <= bus.wdata;
      if (bus.sel == SUB_RISE) rise_q <= bus.wdata;
      if (bus.sel == SUB_FALL) fall_q <= bus.wdata;
    end
  end

  // Checks on the event logic.
  rise_set_a: assert property (@(posedge ref_clk) disable iff (rst)
    ce |=> ((ev_q & $past(rise_ev)) == $past(rise_ev)))
    else $error("Enabled rising edge did not set event.");
  fall_set_a: assert property (@(posedge ref_clk) disable iff (rst)
    ce |=> ((ev_q & $past(fall_ev)) == $past(fall_ev)))
    else $error("Enabled falling edge did not set event.");
  no_spurious_a: assert property (@(posedge ref_clk) disable iff (rst)
    ce |=> ((ev_q & ~$past(ev_q) & ~$past(set_w)) == '0))
    else $error("Event bit set without a filtered edge.");
  read_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
    ce && clr_w && (set_w == '0) |=> (ev_q == '0))
    else $error("Event read did not clear events.");
  cfg_keep_a: assert property (@(posedge ref_clk) disable iff (rst)
    ce && !bus.wr |=> $stable(rise_q) && $stable(fall_q) && $stable(en_q))
    else $error("Configuration changed without a write.");
endmodule

// ---- verification/ssr_ctl_model.sv ----
`timescale 1ns/1ps
// Remote controller on the register port, one access at a time.
module ssr_ctl_model
  import ssr_pkg::*;
(
  // Clock.
  input  wire logic              ref_clk,
  // Register port.
  output logic      [SSR_AW-1:0] reg_addr,
  output logic      [SSR_DW-1:0] reg_wdata,
  output logic                   reg_wr,
  output logic                   reg_rd,
  input  wire logic [SSR_DW-1:0] reg_rdata
);
  // The port is idle at time zero.
  initial begin
    reg_addr  = '0;
    reg_wdata = '0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // One write; the value is already converted from its text form to bits.
  task automatic do_wr(input logic [SSR_AW-1:0] a, input logic [SSR_SW-1:0] v);
    reg_addr  <= a;
    reg_wdata <= {1'b0, v};
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~{1'b0, v};
    @(posedge ref_clk);
  endtask

  // One read; the data stand only in the cycle after the strobe.
  task automatic do_rd(input logic [SSR_AW-1:0] a, output logic [SSR_DW-1:0] d);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
    @(posedge ref_clk);
  endtask
endmodule

// ---- verification/tb_scpi_status_reporting.sv ----
`timescale 1ns/1ps
// Sequences of register accesses with expected values.
module tb_scpi_status_reporting;
  import ssr_pkg::*;
  logic                       ref_clk;
  logic                       ce;
  logic                       rst;
  logic [SSR_AW-1:0]          reg_addr;
  logic [SSR_DW-1:0]          reg_wdata;
  logic                       reg_wr;
  logic                       reg_rd;
  logic [SSR_DW-1:0]          reg_rdata;
  logic [SSR_NGRP*SSR_SW-1:0] hw_cond;
  logic [SSR_EW-1:0]          esr_set;
  logic                       err_queue_busy;
  logic                       msg_avail;
  logic [SSR_EW-1:0]          status_byte;
  logic                       srq;
  logic                       ist;
  int                         err_total;
  int                         check_count;
  int                         cyc;
  localparam int OP4 = 5 * SSR_SW + 4;
  localparam int MS0 = 7 * SSR_SW;

  // Design and controller.
  ssr_top uut (.ref_clk(ref_clk), .ce(ce), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .hw_cond(hw_cond), .esr_set(esr_set), .err_queue_busy(err_queue_busy),
    .msg_avail(msg_avail), .status_byte(status_byte), .srq(srq), .ist(ist));
  ssr_ctl_model ctl (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  // Clock of 100 ns period.
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // Verdict and end of run.
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Compares a seen value with its expected value.
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Register access helpers.
  task automatic wr(input logic [3:0] g, input logic [2:0] s, input logic [14:0] v);
    ctl.do_wr({g, s}, v);
  endtask
  task automatic rd_chk(input string n, input logic [3:0] g, input logic [2:0] s,
                        input logic [15:0] e);
    logic [15:0] d;
    ctl.do_rd({g, s}, d);
    chk(n, d, e);
  endtask

  // Changes one pin and lets it pass the synchroniser and edge detector.
  task automatic pin(input int b, input logic v);
    hw_cond[b] <= v;
    repeat (5) @(posedge ref_clk);
    #1;
  endtask

  // Hang guard.
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      complete_run();
    end
  end

  // Main sequence.
  initial begin
    err_total = 0;
    check_count = 0;
    cyc = 0;
    rst = 1'b1;
    ce = 1'b1;
    hw_cond = '0;
    esr_set = '0;
    err_queue_busy = 1'b0;
    msg_avail = 1'b0;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    // Reset values, read-only places and a distinct mask in every group.
    for (int g = 0; g < SSR_NGRP; g++) begin
      rd_chk("event", g[3:0], SUB_EVT, 16'h0000);
      rd_chk("rise", g[3:0], SUB_RISE, {1'b0, RISE_RST});
      rd_chk("fall", g[3:0], SUB_FALL, {1'b0, FALL_RST});
      wr(g[3:0], SUB_COND, 15'h7FFF);
      rd_chk("cond", g[3:0], SUB_COND, 16'h0000);
      wr(g[3:0], SUB_EN, 15'h4000 | (15'(g) * 15'h0111));
    end
    for (int g = 0; g < SSR_NGRP; g++) begin
      rd_chk("mask", g[3:0], SUB_EN, 16'h4000 | (16'(g) * 16'h0111));
      wr(g[3:0], SUB_EN, 15'h0000);
    end
    // Edges on the measurement bit of the operation group, then on device group bit 14.
    pin(OP4, 1'b1);
    rd_chk("oper event", G_OPER, SUB_EVT, 16'h0010);
    rd_chk("oper event", G_OPER, SUB_EVT, 16'h0000);
    rd_chk("oper cond", G_OPER, SUB_COND, 16'h0010);
    pin(OP4, 1'b0);
    rd_chk("oper event", G_OPER, SUB_EVT, 16'h0000);
    wr(G_OPER, SUB_RISE, 15'h0000);
    wr(G_OPER, SUB_FALL, 15'h0010);
    pin(OP4, 1'b1);
    rd_chk("oper event", G_OPER, SUB_EVT, 16'h0000);
    pin(OP4, 1'b0);
    rd_chk("oper event", G_OPER, SUB_EVT, 16'h0010);
    wr(G_OPER, SUB_RISE, 15'h7FFF);
    pin(14, 1'b1);
    rd_chk("dev event", G_DEV, SUB_EVT, 16'h4000);
    pin(14, 1'b0);
    // Summary path from the measuring group up to the status byte.
    pin(MS0, 1'b1);
    wr(G_OPMEAS, SUB_EN, 15'h0001);
    rd_chk("oper cond", G_OPER, SUB_COND, 16'h0010);
    wr(G_OPER, SUB_EN, 15'h0010);
    wr(G_COM, COM_SRE, 15'h0080);
    wr(G_COM, COM_PPE, 15'h0080);
    msg_avail <= 1'b1;
    err_queue_busy <= 1'b1;
    pin(MS0, 1'b1);
    chk("status byte", {8'h00, status_byte}, 16'h00D4);
    chk("srq", {15'h0000, srq}, 16'h0001);
    chk("ist", {15'h0000, ist}, 16'h0001);
    rd_chk("stb", G_COM, COM_STB, 16'h00D4);
    // Standard event status reached only through its own registers.
    esr_set <= 8'h01;
    @(posedge ref_clk);
    esr_set <= 8'h00;
    wr(G_COM, COM_ESE, 15'h0001);
    pin(MS0, 1'b1);
    chk("status byte", {8'h00, status_byte}, 16'h00F4);
    rd_chk("esr", G_COM, COM_ESR, 16'h0001);
    rd_chk("esr", G_COM, COM_ESR, 16'h0000);
    rd_chk("ese", G_COM, COM_ESE, 16'h0001);
    rd_chk("sre", G_COM, COM_SRE, 16'h0080);
    wr(G_COM, COM_PPE, 15'h0000);
    pin(MS0, 1'b1);
    chk("status byte", {8'h00, status_byte}, 16'h00D4);
    chk("ist", {15'h0000, ist}, 16'h0000);
    rd_chk("ppe", G_COM, COM_PPE, 16'h0000);
    // The message-available bit drops with the output queue.
    msg_avail <= 1'b0;
    pin(MS0, 1'b1);
    chk("status byte", {8'h00, status_byte}, 16'h00C4);
    // A low clock enable ignores the read and keeps the events.
    ce <= 1'b0;
    rd_chk("frozen read", G_OPER, SUB_EVT, 16'h0000);
    ce <= 1'b1;
    rd_chk("oper event", G_OPER, SUB_EVT, 16'h0010);
    rd_chk("oper event", G_OPER, SUB_EVT, 16'h0000);
    // Unmapped places read as zero.
    rd_chk("unmapped", 4'hD, SUB_EVT, 16'h0000);
    rd_chk("unmapped", G_DEV, 3'h5, 16'h0000);
    complete_run();
  end
endmodule
